// >>> osc_div_pkg.sv
// Constants for the oscillator and clock divider block
package osc_div_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 200;
  localparam int OSC_MHZ = 12;
  localparam logic [8:0] OSC_STEP = 9'(2 * OSC_MHZ);
  localparam logic [8:0] OSC_MOD = 9'(CLK_MHZ);
  localparam logic [2:0] CONFIG_CLOCK_OUT_1M_HALF = 3'(OSC_MHZ / 2);
  localparam int POR_TICKS_DEF = 1024;
  localparam int CLEAR_TICKS_DEF = 256;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] COUNT_OFS = 8'h08;
  localparam int CTRL_SRC = 0;
  localparam int CTRL_RA_LO = 1;
  localparam int CTRL_RB_LO = 3;
  localparam int CTRL_CC_LO = 6;
  localparam int CTRL_MASTER = 8;
  localparam int CTRL_LOCK = 9;
  localparam logic [9:0] CTRL_RESET = 10'h000;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0]
  {
    PH_POR = 2'b00,
    PH_CLEAR = 2'b01,
    PH_RUN = 2'b10
  } phase_t;

endpackage : osc_div_pkg

// >>> internal_osc_clock_divider.sv
// Internal oscillator, configuration clock and two-output clock divider
//
// Overview of operation
// - A 12 MHz oscillator times power-on, clearing and master config clock.
// - The config clock runs at 1, 6 or 12 MHz, 1 MHz after reset.
// - The divider counts either the internal oscillator or a user clock.
// - Output A is the source divided by 4, 16, 64 or 256 only.
// - Output B divides by 2, 8, 32, 128, 1024, 4096, 16384 or 65536.
// - Each output has its own ratio, fixed once configuration locks it.
// - The divider has an internal-oscillator and a user-clock variant.
//
// The implementer's own choices: the address map and register access over Wishbone.
`timescale 1ns/10ps
`default_nettype none

module internal_osc_clock_divider
  import osc_div_pkg::*;
#(
  parameter int POR_TICKS = osc_div_pkg::POR_TICKS_DEF,
  parameter int CLEAR_TICKS = osc_div_pkg::CLEAR_TICKS_DEF
)
(
  input wire logic clk_i, // 200 MHz system clock
  input wire logic rst_i, // Synchronous reset, active high
  input wire logic [7:0] adr_i, // Wishbone byte address
  input wire logic [31:0] dat_i, // Wishbone write data
  output logic [31:0] dat_o, // Wishbone read data
  input wire logic [3:0] sel_i, // Wishbone byte selects
  input wire logic we_i, // Wishbone write enable
  input wire logic cyc_i, // Wishbone cycle
  input wire logic stb_i, // Wishbone strobe
  output logic ack_o, // Wishbone acknowledge
  input wire logic user_clk_i, // User clock pin, asynchronous
  output logic div_out_a_o, // First divided output
  output logic div_out_b_o, // Second divided output
  output logic config_clock_out_o, // Config clock, master mode only
  output logic clear_busy_o, // Memory clearing in progress
  output logic por_done_o // Power-on timeout expired
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Counter bit for output A: ratio 4 is bit 1, then every second bit
  function automatic logic [3:0] bit_a(input logic [1:0] code);
    bit_a = {1'b0, code, 1'b1};
  endfunction : bit_a

  // Counter bit for output B; the table jumps a bit after 128
  function automatic logic [3:0] bit_b(input logic [2:0] code);
    logic [3:0] b;
    b = {code, 1'b0};
    if (code[2])
    begin
      b = b + 4'h1;
    end
    bit_b = b;
  endfunction : bit_b

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [8:0] osc_acc, next_osc_acc;
  logic osc_lvl, next_osc_lvl;
  logic osc_rise;
  logic us1, us2, us3, next_us1, next_us2, next_us3;
  logic user_lvl, next_user_lvl;
  logic user_rise;
  logic [15:0] count, next_count;
  logic [2:0] cc_cnt, next_cc_cnt;
  logic cc_lvl, next_cc_lvl;
  logic [9:0] ctrl, next_ctrl;
  phase_t phase, next_phase;
  logic [15:0] ph_cnt, next_ph_cnt;
  logic div_a, next_div_a, div_b, next_div_b, cco, next_cco;
  logic ack, next_ack;
  logic [31:0] rdata, next_rdata;
  logic src_tick;
  logic wr_ctrl;

  assign osc_rise = next_osc_lvl & ~osc_lvl;
  assign user_rise = next_user_lvl & ~user_lvl;
  // Source selection: user clock when the bit is set, oscillator otherwise
  assign src_tick = ctrl[CTRL_SRC] ? user_rise : osc_rise;
  assign wr_ctrl = cyc_i & stb_i & we_i & ~ack & (adr_i == CTRL_OFS);

  // ----------------------------------------------------------------
  // Oscillator and user clock
  // ----------------------------------------------------------------
  // Phase accumulator: 24 half periods per microsecond gives 12 MHz.
  // The edges jitter by one system clock since 200 is not a multiple.
  always_comb
  begin
    next_osc_acc = osc_acc + OSC_STEP;
    next_osc_lvl = osc_lvl;
    if (next_osc_acc >= OSC_MOD)
    begin
      next_osc_acc = next_osc_acc - OSC_MOD;
      next_osc_lvl = ~osc_lvl;
    end
    // Three stages; a level is taken only when stages two and three agree
    next_us1 = user_clk_i;
    next_us2 = us1;
    next_us3 = us2;
    next_user_lvl = (us2 == us3) ? us3 : user_lvl;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      osc_acc <= 9'h000;
      osc_lvl <= 1'b0;
      us1 <= 1'b0;
      us2 <= 1'b0;
      us3 <= 1'b0;
      user_lvl <= 1'b0;
    end
    else
    begin
      osc_acc <= next_osc_acc;
      osc_lvl <= next_osc_lvl;
      us1 <= next_us1;
      us2 <= next_us2;
      us3 <= next_us3;
      user_lvl <= next_user_lvl;
    end
  end

  // ----------------------------------------------------------------
  // Power-on timeout, memory clearing, config clock
  // ----------------------------------------------------------------
  // Both phases count oscillator periods, not system clocks
  always_comb
  begin
    next_phase = phase;
    next_ph_cnt = ph_cnt;
    if (osc_rise && phase != PH_RUN)
    begin
      next_ph_cnt = ph_cnt + 16'h0001;
      case (phase)
        PH_POR:
        begin
          if (ph_cnt == 16'(POR_TICKS - 1))
          begin
            next_phase = PH_CLEAR;
            next_ph_cnt = 16'h0000;
          end
        end
        PH_CLEAR:
        begin
          if (ph_cnt == 16'(CLEAR_TICKS - 1))
          begin
            next_phase = PH_RUN;
          end
        end
        default:
        begin
          next_phase = PH_RUN;
        end
      endcase
    end
    // Config clock: 12 MHz passes the oscillator, others toggle on rises
    next_cc_cnt = cc_cnt;
    next_cc_lvl = cc_lvl;
    case (ctrl[CTRL_CC_LO +: 2])
      2'b01:
      begin
        next_cc_lvl = osc_rise ? ~cc_lvl : cc_lvl;
      end
      2'b10:
      begin
        next_cc_lvl = next_osc_lvl;
      end
      default:
      begin
        // 1 MHz: toggle every six oscillator periods
        if (osc_rise)
        begin
          next_cc_cnt = cc_cnt + 3'h1;
          if (cc_cnt == CONFIG_CLOCK_OUT_1M_HALF - 3'h1)
          begin
            next_cc_cnt = 3'h0;
            next_cc_lvl = ~cc_lvl;
          end
        end
      end
    endcase
    next_cco = ctrl[CTRL_MASTER] & cc_lvl;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      phase <= PH_POR;
      ph_cnt <= 16'h0000;
      cc_cnt <= 3'h0;
      cc_lvl <= 1'b0;
      cco <= 1'b0;
    end
    else
    begin
      phase <= next_phase;
      ph_cnt <= next_ph_cnt;
      cc_cnt <= next_cc_cnt;
      cc_lvl <= next_cc_lvl;
      cco <= next_cco;
    end
  end

  // ----------------------------------------------------------------
  // Shared divider counter
  // ----------------------------------------------------------------
  // One counter serves both outputs, so they stay phase related
  always_comb
  begin
    next_count = src_tick ? count + 16'h0001 : count;
    next_div_a = count[bit_a(ctrl[CTRL_RA_LO +: 2])];
    next_div_b = count[bit_b(ctrl[CTRL_RB_LO +: 3])];
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      count <= 16'h0000;
      div_a <= 1'b0;
      div_b <= 1'b0;
    end
    else
    begin
      count <= next_count;
      div_a <= next_div_a;
      div_b <= next_div_b;
    end
  end

  // ----------------------------------------------------------------
  // Wishbone slave
  // ----------------------------------------------------------------
  // Settings freeze once lock is written; only reset reopens them
  always_comb
  begin
    next_ctrl = ctrl;
    if (wr_ctrl && !ctrl[CTRL_LOCK])
    begin
      if (sel_i[0])
      begin
        next_ctrl[7:0] = dat_i[7:0];
      end
      if (sel_i[1])
      begin
        next_ctrl[9:8] = dat_i[9:8];
      end
    end
    next_ack = cyc_i & stb_i & ~ack;
    next_rdata = 32'h0000_0000;
    // Unmapped addresses still acknowledge, reading zero
    case (adr_i)
      CTRL_OFS:
      begin
        next_rdata = {22'h000000, ctrl};
      end
      STATUS_OFS:
      begin
        next_rdata = {26'h0000000, osc_lvl, div_b, div_a,
                      cc_lvl, clear_busy_o, por_done_o};
      end
      COUNT_OFS:
      begin
        next_rdata = {16'h0000, count};
      end
      default:
      begin
        next_rdata = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl <= CTRL_RESET;
      ack <= 1'b0;
      rdata <= 32'h0000_0000;
    end
    else
    begin
      ctrl <= next_ctrl;
      ack <= next_ack;
      rdata <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign ack_o = ack;
  assign dat_o = rdata;
  assign div_out_a_o = div_a;
  assign div_out_b_o = div_b;
  assign config_clock_out_o = cco;
  assign clear_busy_o = (phase == PH_CLEAR);
  assign por_done_o = (phase != PH_POR);

endmodule : internal_osc_clock_divider

`default_nettype wire

// >>> osc_div_chk.sv
// Port checks for the oscillator and divider block
`timescale 1ns/10ps
`default_nettype none
module osc_div_chk (
  input wire logic clk_i, // Clock
  input wire logic rst_i, // Reset
  input wire logic cyc_i, // Cycle
  input wire logic stb_i, // Strobe
  input wire logic ack_o, // Answer
  input wire logic div_out_a_o, // Output A
  input wire logic div_out_b_o, // Output B
  input wire logic config_clock_out_o, // Config clock
  input wire logic clear_busy_o, // Clearing
  input wire logic por_done_o // Timeout over
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  logic [1:0] ack_d;
  logic [1:0] next_ack_d;
  // Recent answers excuse a jump after a ratio write
  always_comb next_ack_d = {ack_d[0], ack_o};
  always_ff @(posedge clk_i) ack_d <= next_ack_d;
  // Idle request
  sequence s_req;
    cyc_i && stb_i && !ack_o;
  endsequence
  property p_ack_resp;
    s_req |=> ack_o;
  endproperty
  a_ack_resp:
    assert property (p_ack_resp) else $error("no answer");
  property p_ack_pulse;
    ack_o |=> !ack_o;
  endproperty
  a_ack_pulse:
    assert property (p_ack_pulse) else $error("answer held");
  property p_por_hold;
    por_done_o |=> por_done_o;
  endproperty
  a_por_hold:
    assert property (p_por_hold) else $error("timeout flag fell");
  property p_clear_por;
    clear_busy_o |-> por_done_o;
  endproperty
  a_clear_por:
    assert property (p_clear_por) else $error("clear before timeout");
  property p_config_clock_out_hi;
    $rose(config_clock_out_o) && !(|ack_d) |-> config_clock_out_o [*8];
  endproperty
  a_config_clock_out_hi:
    assert property (p_config_clock_out_hi) else $error("config clock high short");
  property p_config_clock_out_lo;
    $fell(config_clock_out_o) && !(|ack_d) |-> !config_clock_out_o [*8];
  endproperty
  a_config_clock_out_lo:
    assert property (p_config_clock_out_lo) else $error("config clock low short");
  property p_div_a;
    $changed(div_out_a_o) && !(|ack_d)
      |=> ($stable(div_out_a_o) || (|ack_d)) [*8];
  endproperty
  a_div_a:
    assert property (p_div_a) else $error("output A too fast");
  property p_div_b;
    $changed(div_out_b_o) && !(|ack_d)
      |=> ($stable(div_out_b_o) || (|ack_d)) [*6];
  endproperty
  a_div_b:
    assert property (p_div_b) else $error("output B too fast");
endmodule : osc_div_chk
bind internal_osc_clock_divider osc_div_chk u_osc_div_chk (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
  .ack_o(ack_o), .div_out_a_o(div_out_a_o), .div_out_b_o(div_out_b_o),
  .config_clock_out_o(config_clock_out_o), .clear_busy_o(clear_busy_o),
  .por_done_o(por_done_o)
);
`default_nettype wire

// >>> tb_top.sv
// Self-checking bench for the oscillator and divider block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import osc_div_pkg::*;
  logic clk_i = 0, rst_i = 1, we_i = 0, cyc_i = 0, stb_i = 0, uclk = 0;
  logic [7:0] adr_i = '0;
  logic [31:0] dat_i = '0;
  logic [31:0] dat_o, q;
  logic ack_o, div_a, div_b, config_clock_out, clr, por, mon;
  int err_count = 0, checked = 0, cyc_n = 0, msel = 0, n;
  always #2.5 clk_i = ~clk_i;
  // User clock of 62 ns, off the system grid
  always #31 uclk = ~uclk;
  assign mon = msel == 0 ? div_a : msel == 1 ? div_b : config_clock_out;
  internal_osc_clock_divider #(.POR_TICKS(4), .CLEAR_TICKS(4))
  u_internal_osc_clock_divider
  (
    .clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i),
    .dat_o(dat_o), .sel_i(4'hf), .we_i(we_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .ack_o(ack_o), .user_clk_i(uclk),
    .div_out_a_o(div_a), .div_out_b_o(div_b),
    .config_clock_out_o(config_clock_out), .clear_busy_o(clr), .por_done_o(por)
  );
  task automatic final_report;
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : final_report
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask : cmp
  // Period within two cycles of the ideal figure
  task automatic near(input int got, input int exp);
    checked++;
    if (got < exp - 2 || got > exp + 2)
    begin
      err_count++;
      $display("wrong value at %0t: period %0d want %0d", $time, got, exp);
    end
  endtask : near
  // Classic cycle, held until ack is sampled high at a rising edge
  task automatic wb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    @(posedge clk_i);
    while (ack_o !== 1'b1)
    begin
      @(posedge clk_i);
    end
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
  endtask : wb
  task automatic hold(ref logic s, input logic v);
    int t;
    t = 0;
    while (s !== v && t < 2000)
    begin
      @(negedge clk_i);
      t++;
    end
    cmp(32'(s), 32'(v));
  endtask : hold
  // Skip a rise that a ratio write may fake, then time one period
  task automatic period(input int sel, output int p);
    int k;
    logic o;
    msel = sel;
    k = 0;
    p = 0;
    @(negedge clk_i);
    o = mon;
    while (k < 3 && p < 20000)
    begin
      @(negedge clk_i);
      p++;
      if (!o && mon)
      begin
        k++;
        if (k < 3)
          p = 0;
      end
      o = mon;
    end
  endtask : period
  task automatic t_start;
    cmp(32'(por), '0);
    wb(1'b0, CTRL_OFS, '0);
    cmp(q, 32'(CTRL_RESET));
    hold(por, 1'b1);
    cmp(32'(clr), 32'h1);
    hold(clr, 1'b0);
    wb(1'b0, STATUS_OFS, '0);
    cmp(32'(q[1:0]), 32'h1);
    $display("start done");
  endtask : t_start
  task automatic t_config_clock_out;
    int f [4] = '{1, 6, 12, 1};
    for (int r = 0; r < 4; r++)
    begin
      wb(1'b1, CTRL_OFS, 32'((r << CTRL_CC_LO) | (1 << CTRL_MASTER)));
      period(2, n);
      near(n, 200 / f[r]);
      hold(config_clock_out, 1'b0);
      wb(1'b1, CTRL_OFS, '0);
      repeat (10) @(posedge clk_i);
      cmp(32'(config_clock_out), '0);
    end
    $display("config clock done");
  endtask : t_config_clock_out
  task automatic t_div;
    for (int c = 0; c < 4; c++)
    begin
      wb(1'b1, CTRL_OFS, 32'((c << CTRL_RA_LO) | (c << CTRL_RB_LO)));
      period(0, n);
      near(n, (4 << (2 * c)) * 200 / 12);
      period(1, n);
      near(n, (2 << (2 * c)) * 200 / 12);
    end
    for (int c = 4; c < 8; c++)
    begin
      wb(1'b1, CTRL_OFS, 32'(c << CTRL_RB_LO));
      wb(1'b0, COUNT_OFS, '0);
      cmp(32'(div_b), 32'(q[2 * c + 1]));
    end
    $display("divider done");
  endtask : t_div
  task automatic t_user;
    wb(1'b1, CTRL_OFS, 32'(1 | (1 << CTRL_RB_LO)));
    period(0, n);
    near(n, 4 * 62 / 5);
    period(1, n);
    near(n, 8 * 62 / 5);
    $display("user clock done");
  endtask : t_user
  task automatic t_lock;
    wb(1'b1, CTRL_OFS, 32'((1 << CTRL_LOCK) | 5));
    wb(1'b1, CTRL_OFS, '0);
    wb(1'b0, CTRL_OFS, '0);
    cmp(q, 32'((1 << CTRL_LOCK) | 5));
    wb(1'b0, 8'h0c, '0);
    cmp(q, '0);
    $display("lock done");
  endtask : t_lock
  initial
  begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    t_start;
    t_config_clock_out;
    t_div;
    t_user;
    t_lock;
    final_report;
  end
  // Hang guard, well past the expected run
  always @(posedge clk_i)
  begin
    cyc_n++;
    if (cyc_n == 60000)
    begin
      err_count++;
      final_report;
    end
  end
endmodule : tb_top
`default_nettype wire
